// [test/fatm_panel_model.sv]
// keypad, reset input, fieldbus and mains supply model for the manager's pins
`timescale 1ns/1ps
module fatm_panel_model
(
	input  wire logic ref_clk,
	output logic      panel_reset_key,
	output logic      panel_auto_on_key,
	output logic      digital_reset_in,
	output logic      serial_reset,
	output logic      mains_ok
);
	logic [2:0] key_lvl = 3'h0;

	assign {digital_reset_in, panel_auto_on_key, panel_reset_key} = key_lvl;

	initial
	begin
		serial_reset = 1'b0;
		mains_ok = 1'b1;
	end

	// key 0 reset, 1 auto-run, 2 digital reset; both levels held long enough for the pin filter
	task automatic press(input int key);
		@(negedge ref_clk);
		key_lvl[key] = 1'b1;
		repeat (6) @(negedge ref_clk);
		key_lvl[key] = 1'b0;
		repeat (6) @(negedge ref_clk);
	endtask

	task automatic serial_cmd();
		@(negedge ref_clk);
		serial_reset = 1'b1;
		@(negedge ref_clk);
		serial_reset = 1'b0;
	endtask

	task automatic mains_cycle();
		@(negedge ref_clk);
		mains_ok = 1'b0;
		repeat (8) @(negedge ref_clk);
		mains_ok = 1'b1;
		repeat (8) @(negedge ref_clk);
	endtask
endmodule

// [test/fault_alarm_trip_manager_tb.sv]
// self-checking bench for the fault alarm trip manager
`timescale 1ns/1ps
module fault_alarm_trip_manager_tb;
	import fatm_pkg::*;
	logic        ref_clk = 1'b0;
	logic        rst_n = 1'b0;
	logic [15:0] fault_i = 16'h0000;
	fatm_cfg_t   cfg_i = 10'h000;
	logic        surface_magnet_motor = 1'b0;
	logic        auto_reset_en = 1'b0;
	logic        serial_reset;
	logic        panel_reset_key;
	logic        panel_auto_on_key;
	logic        digital_reset_in;
	logic        mains_ok;
	fatm_stat_t  stat_o;
	fatm_state_t state_o;
	logic [3:0]  seen;
	int          err_total = 0;
	int          tests_run = 0;
	int          fbit;

	always #2 ref_clk = ~ref_clk;

	fatm_panel_model pnl (.ref_clk(ref_clk), .panel_reset_key(panel_reset_key),
		.panel_auto_on_key(panel_auto_on_key), .digital_reset_in(digital_reset_in),
		.serial_reset(serial_reset), .mains_ok(mains_ok));

	// short counts keep escalation and flashing visible within a few dozen cycles
	fatm_manager #(.ESC_CYCLES(8), .FLASH_CYCLES(4)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
		.fault_i(fault_i), .cfg_i(cfg_i), .surface_magnet_motor(surface_magnet_motor),
		.auto_reset_en(auto_reset_en), .serial_reset(serial_reset), .panel_reset_key(panel_reset_key),
		.panel_auto_on_key(panel_auto_on_key), .digital_reset_in(digital_reset_in),
		.mains_ok(mains_ok), .stat_o(stat_o), .state_o(state_o));

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			err_total++;
			$display("CHECK FAILED at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	task automatic w(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// twelve cycles span three flash phases, so a flashing lamp shows both levels
	task automatic watch();
		seen = 4'h0;
		repeat (12)
		begin
			@(negedge ref_clk);
			seen = seen | {!stat_o.alarm_lamp, stat_o.alarm_lamp, !stat_o.warn_lamp, stat_o.warn_lamp};
		end
	endtask

	task automatic run_ok(input string name);
		chk(state_o, ST_RUN);
		chk(stat_o.motor_run, 1'b1);
		$display("test %s finished", name);
	endtask

	// a lock yields only to a mains cycle, then a plain digital reset applies
	task automatic clear_lock();
		fault_i = 16'h0000;
		pnl.mains_cycle();
		chk(state_o, ST_TRIP);
		pnl.press(2);
		w(1);
	endtask

	task automatic summarize();
		$display("checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial
	begin
		w(3);
		rst_n = 1'b1;
		w(2);
		chk(state_o, ST_HOLD);
		chk({stat_o.stall_det_en, stat_o.phase_chk_en}, 2'h3);
		surface_magnet_motor = 1'b1;
		w(3);
		chk({stat_o.stall_det_en, stat_o.phase_chk_en}, 2'h0);
		pnl.press(1);
		w(1);
		run_ok("power_on");
		fault_i = 16'h0001;
		w(3);
		chk(stat_o.warn_lamp, 1'b1);
		chk(stat_o.disp_code, 5'h01);
		fault_i = 16'h0000;
		w(3);
		chk(stat_o.warn_lamp, 1'b0);
		run_ok("warning");
		fault_i = 16'h0040;
		w(5);
		chk(state_o, ST_RUN);
		w(10);
		chk(state_o, ST_TRIP);
		chk(stat_o.motor_run, 1'b0);
		chk({stat_o.disp_flash, stat_o.disp_code}, 6'h27);
		pnl.serial_cmd();
		w(2);
		chk(state_o, ST_TRIP);
		watch();
		chk(seen, 4'hf);
		fault_i = 16'h0000;
		w(2);
		watch();
		chk(seen, 4'he);
		pnl.press(0);
		chk(state_o, ST_HOLD);
		chk(stat_o.alarm_lamp, 1'b0);
		pnl.press(1);
		run_ok("escalation");
		fault_i = 16'h0100;
		w(14);
		fault_i = 16'h0000;
		w(2);
		chk(state_o, ST_TRIP);
		auto_reset_en = 1'b1;
		w(3);
		run_ok("auto_reset");
		fault_i = 16'h1000;
		w(14);
		fault_i = 16'h0000;
		w(3);
		chk(state_o, ST_LOCK);
		pnl.serial_cmd();
		pnl.press(2);
		pnl.press(0);
		chk(state_o, ST_LOCK);
		watch();
		chk(seen, 4'hd);
		chk({stat_o.disp_flash, stat_o.disp_code}, 6'h2d);
		auto_reset_en = 1'b0;
		clear_lock();
		run_ok("trip_lock");
		for (int i = 14; i < 16; i++)
		begin
			fault_i = 16'h0001 << i;
			w(3);
			chk(state_o, ST_LOCK);
			clear_lock();
		end
		run_ok("lock_codes");
		// every configurable code through every response: codes 2,3,4,10,11
		for (int k = 0; k < 5; k++)
		begin
			fbit = (k < 3) ? k + 1 : k + 6;
			for (int r = 0; r < 4; r++)
			begin
				cfg_i = fatm_cfg_t'(10'(r) << (8 - 2 * k));
				fault_i = 16'h0001 << fbit;
				w(14);
				chk(state_o, (r == 3) ? ST_LOCK : (r == 2) ? ST_TRIP : ST_RUN);
				chk(stat_o.disp_code, (r == 0) ? 5'h00 : 5'(fbit + 1));
				if (r < 2)
					chk(stat_o.warn_lamp, r[0]);
				fault_i = 16'h0000;
				if (r == 3)
					clear_lock();
				pnl.serial_cmd();
				w(2);
				run_ok("response");
			end
		end
		// a second power-on reset in mid-run returns to the held state
		surface_magnet_motor = 1'b0;
		rst_n = 1'b0;
		w(2);
		chk(state_o, ST_HOLD);
		chk(stat_o.motor_run, 1'b0);
		rst_n = 1'b1;
		w(3);
		chk({stat_o.stall_det_en, stat_o.phase_chk_en}, 2'h3);
		chk(state_o, ST_HOLD);
		pnl.press(1);
		w(1);
		run_ok("mid_reset");
		summarize();
	end

	// the sequence needs under 1000 cycles; 5000 leaves ample margin
	initial
	begin
		#20000;
		err_total++;
		summarize();
	end
endmodule

// [verilog/fatm_consts.svh]
// constants for the fault alarm trip manager
`ifndef FATM_CONSTS_SVH
`define FATM_CONSTS_SVH

`define FATM_CLK_MHZ      250
`define FATM_ESC_TIME_US  100
`define FATM_ESC_CYCLES   (`FATM_ESC_TIME_US * `FATM_CLK_MHZ)
`define FATM_FLASH_MS     250
`define FATM_FLASH_CYCLES (`FATM_FLASH_MS * 1000 * `FATM_CLK_MHZ)

// bit n-1 stands for fault code n
`define FATM_WARN_FIXED   16'h39f1
`define FATM_TRIP_FIXED   16'hf9c0
`define FATM_LOCK_FIXED   16'hd000

`endif

// [verilog/fatm_manager.sv]
// fault classification, trip state machine, lamps and display
`timescale 1ns/1ps
`include "fatm_consts.svh"
module fatm_manager
	import fatm_pkg::*;
#(
	parameter int ESC_CYCLES   = `FATM_ESC_CYCLES,
	parameter int FLASH_CYCLES = `FATM_FLASH_CYCLES
)
(
	input  wire logic        ref_clk,
	input  wire logic        rst_n,
	input  wire logic [15:0] fault_i,
	input  wire fatm_cfg_t   cfg_i,
	input  wire logic        surface_magnet_motor,
	input  wire logic        auto_reset_en,
	input  wire logic        serial_reset,
	input  wire logic        panel_reset_key,
	input  wire logic        panel_auto_on_key,
	input  wire logic        digital_reset_in,
	input  wire logic        mains_ok,
	output fatm_stat_t       stat_o,
	output fatm_state_t      state_o
);
	function automatic logic [2:0] resp_cls(input fatm_resp_t r);
		// {lock, trip, warn}
		case (r)
			RESP_WARN: return 3'h1;
			RESP_TRIP: return 3'h3;
			RESP_LOCK: return 3'h7;
			default:   return 3'h0;
		endcase
	endfunction

	function automatic logic [4:0] low_code(input logic [15:0] v);
		logic [4:0] c;
		c = 5'h00;
		for (int i = 15; i >= 0; i--)
		begin
			if (v[i])
				c = 5'(i + 1);
		end
		return c;
	endfunction

	// pins from the panel and terminals
	logic [3:0] pin_lvl;
	logic [3:0] pin_prev_q;

	fatm_sync #(.W(4)) u_sync
	(
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.pin     ({mains_ok, digital_reset_in, panel_auto_on_key, panel_reset_key}),
		.lvl     (pin_lvl)
	);

	wire        mains_s   = pin_lvl[3];
	wire  [2:0] pin_rise  = pin_lvl[2:0] & ~pin_prev_q[2:0];
	wire        key_rst_p = pin_rise[0];
	wire        auto_on_p = pin_rise[1];
	wire        din_rst_p = pin_rise[2];

	// per-code classes
	wire  [2:0] c2  = resp_cls(cfg_i.code2);
	wire  [2:0] c3  = resp_cls(cfg_i.code3);
	wire  [2:0] c4  = resp_cls(cfg_i.code4);
	wire  [2:0] c10 = resp_cls(cfg_i.code10);
	wire  [2:0] c11 = resp_cls(cfg_i.code11);

	wire [15:0] warn_cls = `FATM_WARN_FIXED
		| {5'h00, c11[0], c10[0], 5'h00, c4[0], c3[0], c2[0], 1'b0};
	wire [15:0] trip_cls = `FATM_TRIP_FIXED
		| {5'h00, c11[1], c10[1], 5'h00, c4[1], c3[1], c2[1], 1'b0};
	wire [15:0] lock_cls = `FATM_LOCK_FIXED
		| {5'h00, c11[2], c10[2], 5'h00, c4[2], c3[2], c2[2], 1'b0};

	// escalation timer, one shared for all warn-then-trip faults
	logic [31:0] esc_q;
	wire  [15:0] esc_vec  = fault_i & warn_cls & trip_cls;
	wire         esc_done = (esc_q >= 32'(ESC_CYCLES - 1));

	wire  [15:0] warn_now = fault_i & warn_cls;
	wire  [15:0] trip_now = fault_i & trip_cls & (~warn_cls | {16{esc_done}});
	wire  [15:0] lock_now = trip_now & lock_cls;
	wire         warn_any = |warn_now;

	// flash divider, one-cycle enable toggles the flash phase
	logic [31:0] fl_cnt_q;
	logic        flash_q;
	wire         fl_tick = (fl_cnt_q == 32'(FLASH_CYCLES - 1));

	fatm_state_t st_q;
	fatm_state_t st_d;
	logic  [4:0] code_q;
	logic  [4:0] code_d;
	fatm_stat_t  stat_q;
	fatm_stat_t  stat_d;

	wire   [3:0] code_idx  = 4'(code_q - 5'h01);
	wire         cause_live = (code_q != 5'h00) && fault_i[code_idx];
	wire         ext_rst   = din_rst_p | serial_reset;
	wire         auto_rst  = auto_reset_en & (st_q == ST_TRIP);
	wire         can_trip  = (st_q == ST_RUN) || (st_q == ST_HOLD);

	always_comb
	begin
		st_d   = st_q;
		code_d = code_q;
		case (st_q)
			ST_RUN, ST_HOLD:
			begin
				if (|lock_now)
				begin
					st_d   = ST_LOCK;
					code_d = low_code(lock_now);
				end
				else if (|trip_now)
				begin
					st_d   = ST_TRIP;
					code_d = low_code(trip_now);
				end
				else if (st_q == ST_HOLD && auto_on_p)
					st_d = ST_RUN;
			end
			ST_TRIP:
			begin
				// a live cause blocks every source
				if (!cause_live)
				begin
					if (ext_rst || auto_rst)
						st_d = ST_RUN;
					else if (key_rst_p)
						st_d = ST_HOLD;
				end
			end
			ST_LOCK:
			begin
				// resets are ignored; only a mains loss demotes the lock
				if (!mains_s)
					st_d = ST_TRIP;
			end
			default:
			begin
				st_d   = ST_TRIP;
				code_d = 5'h00;
			end
		endcase
	end

	wire tripped = (st_q == ST_TRIP) || (st_q == ST_LOCK);

	always_comb
	begin
		stat_d              = '0;
		stat_d.motor_run    = (st_q == ST_RUN);
		stat_d.stall_det_en = ~surface_magnet_motor;
		stat_d.phase_chk_en = ~surface_magnet_motor;
		stat_d.disp_flash   = tripped;
		stat_d.disp_code    = tripped ? code_q : low_code(warn_now);
		case (st_q)
			ST_TRIP:
			begin
				stat_d.alarm_lamp = flash_q;
				stat_d.warn_lamp  = cause_live & flash_q;
			end
			ST_LOCK:
			begin
				stat_d.alarm_lamp = flash_q;
				stat_d.warn_lamp  = 1'b1;
			end
			default:
				stat_d.warn_lamp  = warn_any;
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_prev_q <= 4'h0;
			esc_q      <= 32'h0000_0000;
			fl_cnt_q   <= 32'h0000_0000;
			flash_q    <= 1'b0;
		end
		else
		begin
			pin_prev_q <= pin_lvl;
			esc_q      <= (|esc_vec && can_trip && !esc_done) ? esc_q + 32'h1 :
			              (|esc_vec && can_trip) ? esc_q : 32'h0000_0000;
			fl_cnt_q   <= fl_tick ? 32'h0000_0000 : fl_cnt_q + 32'h1;
			flash_q    <= fl_tick ? ~flash_q : flash_q;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_q   <= ST_HOLD;
			code_q <= 5'h00;
			stat_q <= '0;
		end
		else
		begin
			st_q   <= st_d;
			code_q <= code_d;
			stat_q <= stat_d;
		end
	end

	assign stat_o  = stat_q;
	assign state_o = st_q;

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_trip_stops_motor: assert property (st_q != ST_RUN |=> !stat_q.motor_run)
		else $error("motor still driven while not running");
	a_warn_self_clear: assert property ((st_q == ST_RUN && !warn_any) |=> !stat_q.warn_lamp)
		else $error("warning lamp stays without a warning");
	a_serial_reset: assert property ((st_q == ST_TRIP && !cause_live && serial_reset) |=> st_q == ST_RUN)
		else $error("serial reset not taken");
	a_lock_ignores_reset: assert property ((st_q == ST_LOCK && mains_s) |=> st_q == ST_LOCK)
		else $error("trip-lock left with mains present");
	a_auto_skips_lock: assert property ((st_q == ST_LOCK && auto_reset_en) |=> st_q != ST_RUN)
		else $error("auto reset cleared a trip-lock");
	a_lock_lamps: assert property (st_q == ST_LOCK |=> stat_q.warn_lamp && stat_q.alarm_lamp == $past(flash_q))
		else $error("trip-lock lamps wrong");
	a_alarm_code: assert property (st_q == ST_TRIP |=> stat_q.disp_flash && stat_q.disp_code == $past(code_q))
		else $error("alarm code not shown");
	a_cause_blocks: assert property ((st_q == ST_TRIP && cause_live) |=> st_q == ST_TRIP)
		else $error("trip cleared with cause present");
	a_key_no_restart: assert property ((st_q == ST_HOLD && !auto_on_p) |=> st_q != ST_RUN)
		else $error("restart without auto-run key");
	a_spm_disables: assert property (surface_magnet_motor |=> !stat_q.stall_det_en && !stat_q.phase_chk_en)
		else $error("checks active with surface magnet motor");
	a_instant_lock: assert property ((can_trip && (fault_i[14] || fault_i[15])) |=> st_q == ST_LOCK)
		else $error("code 15 or 16 did not lock");
	a_warn_before_trip: assert property ((st_q == ST_RUN && esc_q == 32'h0 && (fault_i & ~esc_vec) == 16'h0)
		|=> st_q == ST_RUN)
		else $error("tripped without escalation delay");
	a_trip_lamps_fade: assert property ((st_q == ST_TRIP && !cause_live) |=> !stat_q.warn_lamp)
		else $error("warning lamp flashes after cause gone");

	// reset paths, lamp phases and the escalation counter
	a_key_to_hold: assert property ((st_q == ST_TRIP && !cause_live && key_rst_p)
		&& !ext_rst && !auto_rst |=> st_q == ST_HOLD)
		else $error("panel reset key did not hold the motor");
	a_digital_reset: assert property ((st_q == ST_TRIP && !cause_live && din_rst_p) |=> st_q == ST_RUN)
		else $error("digital reset not taken");
	a_auto_reset: assert property ((st_q == ST_TRIP && !cause_live && auto_reset_en) |=> st_q == ST_RUN)
		else $error("auto reset not taken");
	a_trip_waits: assert property ((st_q == ST_TRIP && !cause_live && !ext_rst && !auto_rst)
		&& !key_rst_p |=> st_q == ST_TRIP)
		else $error("trip left without a reset");
	a_mains_demotes: assert property ((st_q == ST_LOCK && !mains_s) |=> st_q == ST_TRIP)
		else $error("mains loss did not demote the trip-lock");
	a_lock_keeps_code: assert property (st_q == ST_LOCK |=> code_q == $past(code_q))
		else $error("alarm code changed during trip-lock");
	a_lock_code: assert property (st_q == ST_LOCK |=> stat_q.disp_flash && stat_q.disp_code == $past(code_q))
		else $error("trip-lock code not shown");
	a_trip_code_set: assert property ((can_trip && trip_now != 16'h0) |=> code_q != 5'h00)
		else $error("trip without an alarm code");
	a_trip_alarm_flash: assert property (st_q == ST_TRIP |=> stat_q.alarm_lamp == $past(flash_q))
		else $error("alarm lamp not flashing in trip");
	a_trip_warn_flash: assert property ((st_q == ST_TRIP && cause_live) |=> stat_q.warn_lamp == $past(flash_q))
		else $error("warning lamp not flashing with cause present");
	a_idle_dark: assert property ((st_q == ST_RUN || st_q == ST_HOLD) |=> !stat_q.alarm_lamp && !stat_q.disp_flash)
		else $error("alarm shown without a trip");
	a_warn_lamp_on: assert property (((st_q == ST_RUN || st_q == ST_HOLD) && warn_any) |=> stat_q.warn_lamp)
		else $error("warning lamp off with a warning present");
	a_run_no_code: assert property ((st_q == ST_RUN && warn_now == 16'h0) |=> stat_q.disp_code == 5'h00)
		else $error("code shown without a warning");
	a_run_drives: assert property (st_q == ST_RUN |=> stat_q.motor_run)
		else $error("motor not driven while running");
	a_warn_only_runs: assert property ((st_q == ST_RUN && (fault_i & trip_cls) == 16'h0) |=> st_q == ST_RUN)
		else $error("warning-only fault tripped");
	a_run_key_ignored: assert property ((st_q == ST_RUN && trip_now == 16'h0) |=> st_q == ST_RUN)
		else $error("run left without a trip");
	a_hold_auto_on: assert property ((st_q == ST_HOLD && auto_on_p && trip_now == 16'h0) |=> st_q == ST_RUN)
		else $error("auto-run key did not restart");
	a_lock_class: assert property ((can_trip && lock_now != 16'h0) |=> st_q == ST_LOCK)
		else $error("lock class fault did not lock");
	a_esc_trip: assert property ((can_trip && esc_done && esc_vec != 16'h0) |=> st_q == ST_TRIP || st_q == ST_LOCK)
		else $error("persisting warning did not escalate");
	a_esc_counts: assert property ((can_trip && esc_vec != 16'h0 && !esc_done) |=> esc_q == $past(esc_q) + 32'h1)
		else $error("escalation timer stalled");
	a_esc_clears: assert property (esc_vec == 16'h0 |=> esc_q == 32'h0)
		else $error("escalation timer not cleared");
	a_spm_off_checks: assert property (!surface_magnet_motor |=> stat_q.stall_det_en && stat_q.phase_chk_en)
		else $error("checks disabled without surface magnet motor");
	a_flash_toggle: assert property (fl_tick |=> flash_q != $past(flash_q))
		else $error("flash phase did not toggle");
	a_flash_steady: assert property (!fl_tick |=> flash_q == $past(flash_q))
		else $error("flash phase toggled early");

	c_trip_then_reset: cover property (st_q == ST_TRIP ##[1:1000] st_q == ST_RUN);
	c_lock_power_cycle: cover property (st_q == ST_LOCK ##[1:1000] st_q == ST_TRIP);
	c_key_then_auto_on: cover property (st_q == ST_HOLD ##[1:1000] st_q == ST_RUN);
	c_warn_escalates: cover property ((st_q == ST_RUN && esc_vec != 16'h0) ##[1:1000] st_q == ST_TRIP);
	c_serial_clears: cover property ((st_q == ST_TRIP && serial_reset) ##1 st_q == ST_RUN);
endmodule

// [verilog/fatm_pkg.sv]
// types for the fault alarm trip manager
package fatm_pkg;

	typedef enum logic [1:0]
	{
		RESP_OFF  = 2'h0,
		RESP_WARN = 2'h1,
		RESP_TRIP = 2'h2,
		RESP_LOCK = 2'h3
	} fatm_resp_t;

	typedef struct packed
	{
		fatm_resp_t code2;
		fatm_resp_t code3;
		fatm_resp_t code4;
		fatm_resp_t code10;
		fatm_resp_t code11;
	} fatm_cfg_t;

	typedef struct packed
	{
		logic       motor_run;
		logic       warn_lamp;
		logic       alarm_lamp;
		logic       disp_flash;
		logic [4:0] disp_code;
		logic       stall_det_en;
		logic       phase_chk_en;
	} fatm_stat_t;

	typedef enum logic [3:0]
	{
		ST_RUN  = 4'h1,
		ST_TRIP = 4'h2,
		ST_LOCK = 4'h4,
		ST_HOLD = 4'h8
	} fatm_state_t;

endpackage

// [verilog/fatm_sync.sv]
// three flop synchroniser, a change counts when the last two agree
`timescale 1ns/1ps
module fatm_sync
#(
	parameter int W = 1
)
(
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] lvl
);
	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] lvl_q;

	// filtering on s2/s3 only keeps s1 out of any logic
	wire  [W-1:0] agree = ~(s2_q ^ s3_q);
	wire  [W-1:0] lvl_d = (agree & s3_q) | (~agree & lvl_q);

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			s1_q  <= '0;
			s2_q  <= '0;
			s3_q  <= '0;
			lvl_q <= '0;
		end
		else
		begin
			s1_q  <= pin;
			s2_q  <= s1_q;
			s3_q  <= s2_q;
			lvl_q <= lvl_d;
		end
	end

	assign lvl = lvl_q;
endmodule
